// ---- hw/olps_cfg.svh ----
// constants of the output line pulse stretcher
`ifndef OLPS_CFG_SVH
`define OLPS_CFG_SVH
`define OLPS_CLK_MHZ         20
`define OLPS_MAX_WIDTH_US    100
`define OLPS_WIDTH_BITS      7
`define OLPS_WIDTH_RESET     7'h00
`define OLPS_COUNT_BITS      12
`define OLPS_LINE_OUT        2'h0
`define OLPS_LINE_DED        2'h1
`define OLPS_LINE_GPIO       2'h2
`endif

// ---- hw/olps_pkg.sv ----
// types of the output line pulse stretcher
package olps_pkg;
   typedef enum logic [1:0] {
      OLPS_IDLE    = 2'b00,
      OLPS_PASS    = 2'b01,
      OLPS_STRETCH = 2'b10
   } olps_state_type;
   typedef enum logic [1:0] {
      OLPS_SRC_SIGNAL   = 2'b00,
      OLPS_SRC_SOFTWARE = 2'b01,
      OLPS_SRC_SYNCED   = 2'b10
   } olps_source_type;
endpackage

// ---- hw/olps_stretch.sv ----
// pulse stretcher core: holds a pulse high for a minimum cycle count
`timescale 1ns/1ps
`include "olps_cfg.svh"
module olps_stretch #(
   parameter int COUNT_BITS = `OLPS_COUNT_BITS
) (
   input  wire logic                  ref_clk,
   input  wire logic                  sys_rst,
   input  wire logic                  pulse_in,
   input  wire logic [COUNT_BITS-1:0] min_cycles,
   output logic                       pulse_out
);
   olps_pkg::olps_state_type  state;
   olps_pkg::olps_state_type  next_state;
   logic [COUNT_BITS-1:0]     count;
   logic [COUNT_BITS-1:0]     next_count;
   logic                      pulse_prev;
   wire                       reached = (count + 1'b1 >= min_cycles);

   // ************************************************************
   // leading edge is passed straight through; the count begins at
   // the first high cycle so a short pulse lasts exactly min_cycles
   // ************************************************************
   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         olps_pkg::OLPS_IDLE: begin
            next_count = '0;
            // only a leading edge starts a count, so a long pulse that
            // outlives its minimum is not stretched a second time
            if (pulse_in && !pulse_prev && !(min_cycles <= 1)) begin
               next_state = olps_pkg::OLPS_PASS;
               next_count = COUNT_BITS'(1);
            end
         end
         olps_pkg::OLPS_PASS: begin
            next_count = count + 1'b1;
            if (reached) begin
               next_state = olps_pkg::OLPS_IDLE;
               next_count = '0;
            end else if (!pulse_in) begin
               next_state = olps_pkg::OLPS_STRETCH;
            end
         end
         olps_pkg::OLPS_STRETCH: begin
            next_count = count + 1'b1;
            if (reached) begin
               next_state = olps_pkg::OLPS_IDLE;
               next_count = '0;
            end
         end
         default: begin
            next_state = olps_pkg::OLPS_IDLE;
            next_count = '0;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= olps_pkg::OLPS_IDLE;
         count <= '0;
         pulse_prev <= 1'b0;
      end else begin
         state <= next_state;
         count <= next_count;
         pulse_prev <= pulse_in;
      end
   end

   // output high while the input is high or a count is running
   assign pulse_out = pulse_in || (state != olps_pkg::OLPS_IDLE);
endmodule

// ---- hw/olps_top.sv ----
// output line pulse stretcher top: config, source select, inverter
`timescale 1ns/1ps
`include "olps_cfg.svh"
module olps_top #(
   parameter int WIDTH_BITS = `OLPS_WIDTH_BITS,
   parameter int COUNT_BITS = `OLPS_COUNT_BITS,
   parameter int CLK_MHZ    = `OLPS_CLK_MHZ,
   parameter int MAX_US     = `OLPS_MAX_WIDTH_US
) (
   input  wire logic                  ref_clk,
   input  wire logic                  sys_rst,
   input  wire logic [1:0]            line_config_select,
   input  wire logic                  select_write,
   input  wire logic                  direction_write,
   input  wire logic                  direction_value,
   input  wire logic                  width_write,
   input  wire logic [WIDTH_BITS-1:0] width_value,
   input  wire logic                  source_write,
   input  wire logic [1:0]            source_value,
   input  wire logic                  inverter_write,
   input  wire logic                  inverter_value,
   input  wire logic                  level_write,
   input  wire logic                  level_value,
   input  wire logic                  software_level_select,
   input  wire logic                  frame_synced_software_level,
   input  wire logic                  internal_signal,
   input  wire logic                  sequencer_advance,
   input  wire logic                  gpio_in,
   output logic                       line_out,
   output logic                       gpio_out,
   output logic                       gpio_oe,
   output logic [1:0]                 selected_line,
   output logic                       line_direction,
   output logic                       gpio_direction,
   output logic [WIDTH_BITS-1:0]      min_pulse_width_us,
   output logic [WIDTH_BITS-1:0]      gpio_width_us,
   output logic [1:0]                 line_drive_source,
   output logic                       line_inverted,
   output logic                       software_line_level,
   output logic                       gpio_input_level
);
   logic [WIDTH_BITS-1:0] next_width;
   logic                  stretched;
   logic                  gpio_stretched;
   logic                  pre_inverter;

   // ************************************************************
   // configuration writes
   // ************************************************************
   function automatic logic [WIDTH_BITS-1:0] olps_clamp(
      input logic [WIDTH_BITS-1:0] value);
      // values above the range saturate rather than wrap
      olps_clamp = (value > WIDTH_BITS'(MAX_US)) ?
                   WIDTH_BITS'(MAX_US) : value;
   endfunction

   function automatic logic [COUNT_BITS-1:0] olps_cycles(
      input logic [WIDTH_BITS-1:0] us);
      olps_cycles = COUNT_BITS'(us * CLK_MHZ);
   endfunction

   assign next_width = olps_clamp(width_value);

   // ************************************************************
   // write decode: one named strobe per register except selected_line, which takes select_write directly;
   // line_direction also loads on a select_write whose line_config_select picks the dedicated line
   // ************************************************************
   wire sel_ded       = (selected_line == `OLPS_LINE_DED);
   wire sel_gpio      = (selected_line == `OLPS_LINE_GPIO);
   wire pick_ded      = (line_config_select == `OLPS_LINE_DED);
   wire ded_dir_we    = direction_write && sel_ded;
   wire gpio_dir_we   = direction_write && sel_gpio;
   wire ded_width_we  = width_write && sel_ded;
   // an input-mode third line ignores width writes
   wire gpio_width_we = width_write && sel_gpio && gpio_direction;
   wire source_we     = source_write && sel_ded;
   wire inverter_we   = inverter_write && sel_ded;
   // sequencer_advance is deliberately not a term of the level write
   wire level_we      = level_write && !software_level_select;

   // ************************************************************
   // configuration registers
   // ************************************************************
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         selected_line <= `OLPS_LINE_DED;
      end else if (select_write) begin
         selected_line <= line_config_select;
      end
   end

   // the dedicated line cannot be turned into an input
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         line_direction <= 1'b1;
      end else if (select_write && pick_ded) begin
         line_direction <= 1'b1;
      end else if (!select_write && ded_dir_we) begin
         line_direction <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gpio_direction <= 1'b0;
      end else if (gpio_dir_we) begin
         gpio_direction <= direction_value;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         min_pulse_width_us <= `OLPS_WIDTH_RESET;
      end else if (ded_width_we) begin
         min_pulse_width_us <= next_width;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gpio_width_us <= `OLPS_WIDTH_RESET;
      end else if (gpio_width_we) begin
         gpio_width_us <= next_width;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         line_drive_source <= olps_pkg::OLPS_SRC_SIGNAL;
      end else if (source_we) begin
         line_drive_source <= source_value;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         line_inverted <= 1'b0;
      end else if (inverter_we) begin
         line_inverted <= inverter_value;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         software_line_level <= 1'b0;
      end else if (level_we) begin
         software_line_level <= level_value;
      end
   end

   // ************************************************************
   // datapath
   // ************************************************************
   // unknown source codes fall back to the stretched signal
   function automatic logic olps_source_pick(
      input logic [1:0] source,
      input logic       signal_level,
      input logic       soft_level,
      input logic       synced_level);
      case (source)
         olps_pkg::OLPS_SRC_SOFTWARE: olps_source_pick = soft_level;
         olps_pkg::OLPS_SRC_SYNCED:   olps_source_pick = synced_level;
         default:                     olps_source_pick = signal_level;
      endcase
   endfunction

   wire [COUNT_BITS-1:0] ded_cycles  = olps_cycles(min_pulse_width_us);
   wire [COUNT_BITS-1:0] gpio_cycles = olps_cycles(gpio_width_us);

   olps_stretch #(.COUNT_BITS(COUNT_BITS)) u_stretch (
      .ref_clk    (ref_clk),
      .sys_rst    (sys_rst),
      .pulse_in   (internal_signal),
      .min_cycles (ded_cycles),
      .pulse_out  (stretched)
   );

   olps_stretch #(.COUNT_BITS(COUNT_BITS)) u_gpio_stretch (
      .ref_clk    (ref_clk),
      .sys_rst    (sys_rst),
      .pulse_in   (internal_signal),
      .min_cycles (gpio_cycles),
      .pulse_out  (gpio_stretched)
   );

   // the software level enters ahead of the inverter
   assign pre_inverter = olps_source_pick(line_drive_source, stretched,
      software_line_level, frame_synced_software_level);

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         line_out <= 1'b0;
      end else begin
         line_out <= pre_inverter ^ line_inverted;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gpio_out <= 1'b0;
      end else begin
         gpio_out <= gpio_stretched;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gpio_input_level <= 1'b0;
      end else begin
         gpio_input_level <= gpio_in;
      end
   end

   assign gpio_oe = gpio_direction;
endmodule

// ---- test/olps_properties.sv ----
// assertions on the ports of the output line pulse stretcher
`timescale 1ns/1ps
module olps_properties #(
   parameter int WIDTH_BITS = 7,
   parameter int CLK_MHZ    = 20,
   parameter int MAX_US     = 100
) (
   input wire logic ref_clk, sys_rst, select_write, width_write, level_write,
   input wire logic level_value, software_level_select, internal_signal,
   input wire logic sequencer_advance, line_out, line_direction,
   input wire logic gpio_direction, line_inverted, software_line_level,
   input wire logic [1:0] line_config_select, selected_line, line_drive_source,
   input wire logic [WIDTH_BITS-1:0] width_value, min_pulse_width_us,
   input wire logic [WIDTH_BITS-1:0] gpio_width_us
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   int hi_cnt;
   // length of the current high run on the line, read where it falls
   always_ff @(posedge ref_clk or posedge sys_rst)
      if (sys_rst) hi_cnt <= 0;
      else hi_cnt <= line_out ? hi_cnt + 1 : 0;
   a_stretch_min_width: assert property (
      $fell(line_out) && line_drive_source == 2'h0 && !line_inverted
      |-> hi_cnt >= CLK_MHZ * min_pulse_width_us)
      else $error("line pulse shorter than the minimum width");
   a_leading_edge_kept: assert property (
      line_drive_source == 2'h0 && !line_inverted && internal_signal
      |=> line_out)
      else $error("line not high one cycle after the signal");
   a_width_clamp: assert property (
      width_write && !select_write && selected_line == 2'h1
      |=> min_pulse_width_us == ($past(width_value) > MAX_US ?
          MAX_US : $past(width_value)))
      else $error("minimum width readback wrong");
   a_dedicated_output: assert property (
      select_write && line_config_select == 2'h1
      |=> selected_line == 2'h1 && line_direction)
      else $error("dedicated line not set to output");
   a_gpio_input_ignored: assert property (
      width_write && selected_line == 2'h2 && !gpio_direction
      |=> $stable(gpio_width_us))
      else $error("width taken on a line set to input");
   a_level_readback: assert property (
      level_write && !software_level_select
      |=> software_line_level == $past(level_value))
      else $error("software level readback differs from write");
   a_sequencer_ignored: assert property (
      sequencer_advance && !level_write |=> $stable(software_line_level))
      else $error("software level moved on a sequencer advance");
   a_soft_drive: assert property (
      line_drive_source == 2'h1
      |=> line_out == ($past(software_line_level) ^ $past(line_inverted)))
      else $error("line does not follow the software level");
endmodule
bind olps_top olps_properties #(.WIDTH_BITS(WIDTH_BITS), .CLK_MHZ(CLK_MHZ),
   .MAX_US(MAX_US)) u_props (.*);

// ---- test/olps_receiver.sv ----
// far-side receiver model: measures each high pulse on the output line
`timescale 1ns/1ps
module olps_receiver (
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        line,
   output logic             pulse_seen,
   output logic [11:0]      pulse_width
);
   logic [11:0] run;
   // a real receiver has no reset; clearing here keeps the first width clean
   always_ff @(posedge ref_clk or posedge sys_rst)
      if (sys_rst) begin
         run <= 12'h000;
         pulse_seen <= 1'h0;
         pulse_width <= 12'h000;
      end else begin
         run <= line ? run + 12'h001 : 12'h000;
         pulse_seen <= !line && run != 12'h000;
         pulse_width <= run;
      end
endmodule

// ---- test/olps_top_tb.sv ----
// self-checking bench of the output line pulse stretcher
`timescale 1ns/1ps
`include "olps_cfg.svh"
module olps_top_tb;
   logic ref_clk = 1'h0, sys_rst = 1'h1, select_write = 1'h0;
   logic direction_write = 1'h0, direction_value = 1'h0, width_write = 1'h0;
   logic source_write = 1'h0, inverter_write = 1'h0, inverter_value = 1'h0;
   logic level_write = 1'h0, level_value = 1'h0, gpio_in = 1'h0;
   logic software_level_select = 1'h0, frame_synced_software_level = 1'h0;
   logic internal_signal = 1'h0, sequencer_advance = 1'h0;
   logic [1:0] line_config_select = 2'h0, source_value = 2'h0;
   logic [6:0] width_value = 7'h00;
   logic line_out, gpio_out, gpio_oe, line_direction, gpio_direction;
   logic line_inverted, software_line_level, gpio_input_level, pulse_seen;
   logic [1:0] selected_line, line_drive_source;
   logic [6:0] min_pulse_width_us, gpio_width_us;
   logic [11:0] pulse_width;
   logic [11:0] exp_q[$];
   int mismatches = 0, comparisons = 0, k, m;
   bit watch = 1;
   always #25 ref_clk = ~ref_clk;
   olps_top u_dut (.*);
   olps_receiver u_rx (.ref_clk, .sys_rst, .line(line_out), .pulse_seen,
      .pulse_width);
   task automatic chk(input logic [11:0] got, input logic [11:0] want);
      comparisons++;
      if (got !== want) begin
         mismatches++;
         $display("unexpected at %0t: got %0h want %0h", $time, got, want);
      end
   endtask
   // bit 6 and bit 5 of v also steer the level select and sequencer inputs
   task automatic put(input int s, input logic [6:0] v);
      @(posedge ref_clk);
      select_write <= s == 0;
      direction_write <= s == 1;
      width_write <= s == 2;
      source_write <= s == 3;
      inverter_write <= s == 4;
      level_write <= s == 5;
      {line_config_select, source_value} <= {v[1:0], v[1:0]};
      {direction_value, inverter_value, level_value} <= {3{v[0]}};
      width_value <= v;
      {software_level_select, sequencer_advance} <= v[6:5];
      @(posedge ref_clk);
      {select_write, direction_write, width_write} <= 3'h0;
      {source_write, inverter_write, level_write} <= 3'h0;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   task automatic pulse(input int k, input int e);
      exp_q.push_back(e[11:0]);
      @(posedge ref_clk);
      internal_signal <= 1'h1;
      repeat (k) @(posedge ref_clk);
      internal_signal <= 1'h0;
      repeat (e + 6) @(posedge ref_clk);
   endtask
   task automatic final_report;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge ref_clk)
      if (pulse_seen) begin
         if (exp_q.size() != 0)
            chk(pulse_width, exp_q.pop_front());
         else if (watch)
            chk(pulse_width, 12'h000);
      end
   initial begin
      #500000;
      mismatches++;
      final_report();
   end
   initial begin
      void'($urandom(32'hCEA275B7));
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'h0;
      put(7, 7'h00);
      chk({selected_line, line_direction, line_drive_source,
         min_pulse_width_us}, 12'h600);
      put(2, 7'h78);
      chk(min_pulse_width_us, 7'h64);
      for (int w = 0; w < 3; w++) begin
         put(2, w[6:0]);
         m = w * `OLPS_CLK_MHZ;
         for (int j = 0; j < 4; j++) begin
            k = j == 0 ? 1 : j == 1 ? m + (m == 0) : j == 2 ? m + 3 :
               1 + $urandom % 60;
            pulse(k, k > m ? k : m);
         end
      end
      put(0, `OLPS_LINE_GPIO);
      put(2, 7'h05);
      chk(gpio_width_us, 7'h00);
      put(1, 7'h01);
      put(2, 7'h05);
      chk({gpio_oe, gpio_width_us}, 8'h85);
      // one-cycle pulse: line keeps 2 us (40 cycles), third line 5 us
      exp_q.push_back(12'h028);
      @(posedge ref_clk);
      {internal_signal, gpio_in} <= 2'h3;
      @(posedge ref_clk);
      internal_signal <= 1'h0;
      repeat (98) @(posedge ref_clk);
      #1;
      chk({gpio_out, gpio_input_level}, 2'h3);
      repeat (4) @(posedge ref_clk);
      #1;
      chk(gpio_out, 1'h0);
      put(0, `OLPS_LINE_DED);
      put(1, 7'h00);
      chk({selected_line, line_direction}, 3'h3);
      watch = 0;
      put(5, 7'h01);
      chk(line_out, 1'h0);
      put(3, 7'h01);
      chk({software_line_level, line_out}, 2'h3);
      put(4, 7'h01);
      chk(line_out, 1'h0);
      put(5, 7'h60);
      chk(software_line_level, 1'h1);
      put(5, 7'h00);
      chk({software_line_level, line_out}, 2'h1);
      @(posedge ref_clk);
      frame_synced_software_level <= 1'h1;
      put(3, 7'h02);
      chk(line_out, 1'h0);
      chk(12'(exp_q.size()), 12'h000);
      final_report();
   end
endmodule
